// [verilog/gpao_params.svh]
// register offsets, reset values and field positions for the gpio port block
`ifndef GPAO_PARAMS_SVH
`define GPAO_PARAMS_SVH
`define GPAO_OFS_B_OUT   8'h00
`define GPAO_OFS_B_DIR   8'h04
`define GPAO_OFS_B_PIN   8'h08
`define GPAO_OFS_C_OUT   8'h0c
`define GPAO_OFS_C_DIR   8'h10
`define GPAO_OFS_C_PIN   8'h14
`define GPAO_OFS_D_OUT   8'h18
`define GPAO_OFS_D_DIR   8'h1c
`define GPAO_OFS_D_PIN   8'h20
`define GPAO_OFS_E_OUT   8'h24
`define GPAO_OFS_E_DIR   8'h28
`define GPAO_OFS_E_PIN   8'h2c
`define GPAO_OFS_ALT     8'h30
`define GPAO_RST_BYTE    8'h00
`define GPAO_RST_E       3'h0
`define GPAO_E_MASK      8'h07
`define GPAO_ALT_TMR_BIT 0
`define GPAO_ALT_ADC_BIT 1
`define GPAO_RESP_OKAY   2'h0
`define GPAO_RESP_SLVERR 2'h2
`define GPAO_AW          8
`endif

// [verilog/gpao_pkg.sv]
// types shared by the gpio port block
package gpao_pkg;
  typedef struct packed {
    logic pu_oe;
    logic pu_ov;
    logic dd_oe;
    logic dd_ov;
    logic pv_oe;
    logic pv_ov;
    logic die_oe;
    logic die_ov;
  } gpao_ovr_t;
  typedef enum logic [1:0] {GPAO_W_IDLE, GPAO_W_RESP} gpao_wst_t;
  typedef enum logic [1:0] {GPAO_R_IDLE, GPAO_R_RESP} gpao_rst_t;
endpackage : gpao_pkg

// [verilog/gpao_pin.sv]
// one pin: override muxing and registered pad controls
`timescale 1ns/1ps
module gpao_pin (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              latch,
  input  wire logic              dir,
  input  wire logic              pin_i,
  input  wire gpao_pkg::gpao_ovr_t ovr,
  output logic                   pad_o,
  output logic                   pad_oe,
  output logic                   pad_pu,
  output logic                   level
);
  logic o_nxt, oe_nxt, pu_nxt, lv_nxt;
  logic o_r, oe_r, pu_r, s1_r, lv_r;
  logic dir_eff, die;
  always_comb begin
    dir_eff = ovr.dd_oe ? ovr.dd_ov : dir; // RULE12
    oe_nxt  = dir_eff;
    o_nxt   = ovr.pv_oe ? ovr.pv_ov : latch; // RULE12
    pu_nxt  = ovr.pu_oe ? ovr.pu_ov : (latch & ~dir_eff); // RULE12
    die     = ovr.die_oe ? ovr.die_ov : 1'b1; // RULE12
    lv_nxt  = die ? s1_r : 1'b0; // RULE13
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      o_r  <= 1'b0;
      oe_r <= 1'b0;
      pu_r <= 1'b0;
      s1_r <= 1'b0;
      lv_r <= 1'b0;
    end else if (ce) begin
      o_r  <= o_nxt;
      oe_r <= oe_nxt;
      pu_r <= pu_nxt;
      s1_r <= pin_i;
      lv_r <= lv_nxt;
    end
  end
  assign pad_o  = o_r;
  assign pad_oe = oe_r;
  assign pad_pu = pu_r;
  assign level  = lv_r;
endmodule : gpao_pin

// [verilog/gpao_top.sv]
// gpio ports b, c, d and e with alternate-function overrides on port e
//
// How it works
// [RULE1] A crystal oscillator using port e bit 2 takes that pin away from gpio.
// [RULE2] Port e bit 1 is the oscillator input for any clock but the rc one, and then not gpio.
// [RULE3] Software sets port e bit 1 direction to one before compare-b output appears.
// [RULE4] An active compare-b output enable replaces the port e bit 1 output with the waveform.
// [RULE5] With the reset-disable fuse programmed, port e bit 0 is an ordinary pin.
// [RULE6] With the fuse unprogrammed, port e bit 0 feeds reset and is no gpio pin.
// [RULE7] As reset input, port e bit 0 reads zero in direction, latch and level.
// [RULE8] Port b, c, d output latches are read/write and reset to zero.
// [RULE9] Port b, c, d direction registers are read/write and reset to zero.
// [RULE10] Pin level registers follow the pins and have no reset value of meaning.
// [RULE11] Port e registers implement bits 2 to 0; bits 7 to 3 read zero.
// [RULE12] An active override enable selects the alternate value over the register setting.
// [RULE13] Pin level reads give the synchronised pin unless digital input is disabled.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "gpao_params.svh"
module gpao_top #(
  parameter int W  = 8,
  parameter int WE = 3
) (
  input  wire logic                REF_CLK,
  input  wire logic                ARST_N,
  input  wire logic                CE,
  input  wire logic [`GPAO_AW-1:0] S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [`GPAO_AW-1:0] S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  input  wire logic [3*W-1:0]      PIN_I,
  output logic [3*W-1:0]           PIN_O,
  output logic [3*W-1:0]           PIN_OE,
  output logic [3*W-1:0]           PIN_PU,
  input  wire logic [WE-1:0]       PORT_E_I,
  output logic [WE-1:0]            PORT_E_O,
  output logic [WE-1:0]            PORT_E_OE,
  output logic [WE-1:0]            PORT_E_PU,
  input  wire logic                OSC_XTAL_MODE,
  input  wire logic                OSC_EXT_CLK_MODE,
  input  wire logic                RESET_PIN_DISABLE_FUSE,
  input  wire logic                TIMER0_CMP_B_WAVE,
  output logic                     RESET_PIN_LEVEL
);
  logic rs1_r, rs2_r, rst_n;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_n = rs2_r;

  // software state
  logic [3*W-1:0] latch_r, latch_nxt, dir_r, dir_nxt;
  logic [WE-1:0]  e_latch_r, e_latch_nxt, e_dir_r, e_dir_nxt;
  logic [1:0]     alt_r, alt_nxt;
  logic [3*W-1:0] lvl;
  logic [WE-1:0]  e_lvl;
  logic           rst_pin_mode, e0_gpio, e1_osc, e2_osc;

  // bus state
  gpao_pkg::gpao_wst_t wst_r, wst_nxt;
  gpao_pkg::gpao_rst_t rst_st_r, rst_st_nxt;
  logic                awr_r, awr_nxt, wr_r, wr_nxt, arr_r, arr_nxt;
  logic                aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [`GPAO_AW-1:0] awa_r, awa_nxt;
  logic [31:0]         wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]          ws_r, ws_nxt;
  logic [1:0]          bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic                bv_r, bv_nxt, rv_r, rv_nxt;
  logic                do_wr;
  logic                rl_r, rl_nxt;

  assign rst_pin_mode = ~RESET_PIN_DISABLE_FUSE; // RULE6
  assign e0_gpio      = RESET_PIN_DISABLE_FUSE; // RULE5
  assign e1_osc       = OSC_EXT_CLK_MODE | OSC_XTAL_MODE; // RULE2
  assign e2_osc       = OSC_XTAL_MODE; // RULE1

  function automatic logic [31:0] rd_word(input logic [`GPAO_AW-1:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `GPAO_OFS_B_OUT: v[W-1:0] = latch_r[W-1:0]; // RULE8
      `GPAO_OFS_B_DIR: v[W-1:0] = dir_r[W-1:0]; // RULE9
      `GPAO_OFS_B_PIN: v[W-1:0] = lvl[W-1:0]; // RULE10
      `GPAO_OFS_C_OUT: v[W-1:0] = latch_r[2*W-1:W];
      `GPAO_OFS_C_DIR: v[W-1:0] = dir_r[2*W-1:W];
      `GPAO_OFS_C_PIN: v[W-1:0] = lvl[2*W-1:W];
      `GPAO_OFS_D_OUT: v[W-1:0] = latch_r[3*W-1:2*W];
      `GPAO_OFS_D_DIR: v[W-1:0] = dir_r[3*W-1:2*W];
      `GPAO_OFS_D_PIN: v[W-1:0] = lvl[3*W-1:2*W];
      `GPAO_OFS_E_OUT: v[WE-1:0] = {e_latch_r[WE-1:1], e_latch_r[0] & e0_gpio}; // RULE7 RULE11
      `GPAO_OFS_E_DIR: v[WE-1:0] = {e_dir_r[WE-1:1], e_dir_r[0] & e0_gpio}; // RULE7 RULE11
      `GPAO_OFS_E_PIN: v[WE-1:0] = {e_lvl[WE-1:1], e_lvl[0] & e0_gpio}; // RULE7 RULE11
      `GPAO_OFS_ALT:   v[1:0] = alt_r;
      default:         v = 32'h0;
    endcase
    return v;
  endfunction : rd_word

  function automatic logic known(input logic [`GPAO_AW-1:0] a);
    return (a <= `GPAO_OFS_ALT) && (a[1:0] == 2'h0);
  endfunction : known

  // axi4-lite write and read channels
  always_comb begin
    wst_nxt    = wst_r;
    awr_nxt    = awr_r;
    wr_nxt     = wr_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    bv_nxt     = bv_r;
    bresp_nxt  = bresp_r;
    do_wr      = 1'b0;
    case (wst_r)
      gpao_pkg::GPAO_W_IDLE: begin
        if (S_AXI_AWVALID && awr_r) begin
          aw_got_nxt = 1'b1;
          awa_nxt    = S_AXI_AWADDR;
          awr_nxt    = 1'b0;
        end
        if (S_AXI_WVALID && wr_r) begin
          w_got_nxt = 1'b1;
          wd_nxt    = S_AXI_WDATA;
          ws_nxt    = S_AXI_WSTRB;
          wr_nxt    = 1'b0;
        end
        if (aw_got_r && w_got_r) begin
          do_wr      = 1'b1;
          bv_nxt     = 1'b1;
          bresp_nxt  = known(awa_r) ? `GPAO_RESP_OKAY : `GPAO_RESP_SLVERR;
          aw_got_nxt = 1'b0;
          w_got_nxt  = 1'b0;
          wst_nxt    = gpao_pkg::GPAO_W_RESP;
        end
      end
      gpao_pkg::GPAO_W_RESP: begin
        if (S_AXI_BREADY) begin
          bv_nxt  = 1'b0;
          awr_nxt = 1'b1;
          wr_nxt  = 1'b1;
          wst_nxt = gpao_pkg::GPAO_W_IDLE;
        end
      end
      default: wst_nxt = gpao_pkg::GPAO_W_IDLE;
    endcase
    rst_st_nxt = rst_st_r;
    arr_nxt    = arr_r;
    rv_nxt     = rv_r;
    rd_nxt     = rd_r;
    rresp_nxt  = rresp_r;
    case (rst_st_r)
      gpao_pkg::GPAO_R_IDLE: begin
        if (S_AXI_ARVALID && arr_r) begin
          arr_nxt    = 1'b0;
          rv_nxt     = 1'b1;
          rd_nxt     = rd_word(S_AXI_ARADDR);
          rresp_nxt  = known(S_AXI_ARADDR) ? `GPAO_RESP_OKAY : `GPAO_RESP_SLVERR;
          rst_st_nxt = gpao_pkg::GPAO_R_RESP;
        end
      end
      gpao_pkg::GPAO_R_RESP: begin
        if (S_AXI_RREADY) begin
          rv_nxt     = 1'b0;
          arr_nxt    = 1'b1;
          rst_st_nxt = gpao_pkg::GPAO_R_IDLE;
        end
      end
      default: rst_st_nxt = gpao_pkg::GPAO_R_IDLE;
    endcase
  end

  // register writes, byte lane 0 only
  always_comb begin
    latch_nxt   = latch_r;
    dir_nxt     = dir_r;
    e_latch_nxt = e_latch_r;
    e_dir_nxt   = e_dir_r;
    alt_nxt     = alt_r;
    if (do_wr && ws_r[0]) begin
      case (awa_r)
        `GPAO_OFS_B_OUT: latch_nxt[W-1:0]     = wd_r[W-1:0]; // RULE8
        `GPAO_OFS_B_DIR: dir_nxt[W-1:0]       = wd_r[W-1:0]; // RULE9
        `GPAO_OFS_C_OUT: latch_nxt[2*W-1:W]   = wd_r[W-1:0]; // RULE8
        `GPAO_OFS_C_DIR: dir_nxt[2*W-1:W]     = wd_r[W-1:0]; // RULE9
        `GPAO_OFS_D_OUT: latch_nxt[3*W-1:2*W] = wd_r[W-1:0]; // RULE8
        `GPAO_OFS_D_DIR: dir_nxt[3*W-1:2*W]   = wd_r[W-1:0]; // RULE9
        `GPAO_OFS_E_OUT: e_latch_nxt          = wd_r[WE-1:0]; // RULE11
        `GPAO_OFS_E_DIR: e_dir_nxt            = wd_r[WE-1:0]; // RULE11
        `GPAO_OFS_ALT:   alt_nxt              = wd_r[1:0];
        default:         alt_nxt              = alt_r;
      endcase
    end
    rl_nxt = e_lvl[0] | e0_gpio;
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wst_r     <= gpao_pkg::GPAO_W_IDLE;
      rst_st_r  <= gpao_pkg::GPAO_R_IDLE;
      awr_r     <= 1'b1;
      wr_r      <= 1'b1;
      arr_r     <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awa_r     <= '0;
      wd_r      <= 32'h0;
      ws_r      <= 4'h0;
      bv_r      <= 1'b0;
      bresp_r   <= `GPAO_RESP_OKAY;
      rv_r      <= 1'b0;
      rd_r      <= 32'h0;
      rresp_r   <= `GPAO_RESP_OKAY;
      latch_r   <= '0; // RULE8
      dir_r     <= '0; // RULE9
      e_latch_r <= `GPAO_RST_E;
      e_dir_r   <= `GPAO_RST_E;
      alt_r     <= 2'h0;
      rl_r      <= 1'b1;
    end else if (CE) begin
      wst_r     <= wst_nxt;
      rst_st_r  <= rst_st_nxt;
      awr_r     <= awr_nxt;
      wr_r      <= wr_nxt;
      arr_r     <= arr_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awa_r     <= awa_nxt;
      wd_r      <= wd_nxt;
      ws_r      <= ws_nxt;
      bv_r      <= bv_nxt;
      bresp_r   <= bresp_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      rresp_r   <= rresp_nxt;
      latch_r   <= latch_nxt;
      dir_r     <= dir_nxt;
      e_latch_r <= e_latch_nxt;
      e_dir_r   <= e_dir_nxt;
      alt_r     <= alt_nxt;
      rl_r      <= rl_nxt;
    end
  end

  // ports b, c, d: no overrides in this block
  genvar g;
  for (g = 0; g < 3*W; g++) begin : g_bcd
    gpao_pin u_pin (
      .clk(REF_CLK), .rst_n(rst_n), .ce(CE),
      .latch(latch_r[g]), .dir(dir_r[g]), .pin_i(PIN_I[g]),
      .ovr('0),
      .pad_o(PIN_O[g]), .pad_oe(PIN_OE[g]), .pad_pu(PIN_PU[g]), .level(lvl[g])
    );
  end

  // port e override table
  gpao_pkg::gpao_ovr_t e_ovr [WE];
  always_comb begin
    for (int i = 0; i < WE; i++) begin
      e_ovr[i] = '0;
    end
    // clock and reset uses force the pin to a quiet input, digital input left on
    e_ovr[0] = rst_pin_mode ? 8'hab : 8'h00; // RULE6
    e_ovr[1].pv_oe = alt_r[`GPAO_ALT_TMR_BIT] & ~e1_osc; // RULE4
    e_ovr[1].pv_ov = TIMER0_CMP_B_WAVE; // RULE4
    if (e1_osc) begin
      e_ovr[1] = 8'hab; // RULE2
    end
    e_ovr[2].die_oe = alt_r[`GPAO_ALT_ADC_BIT]; // RULE13
    if (e2_osc) begin
      e_ovr[2] = 8'hab; // RULE1
    end
  end

  for (g = 0; g < WE; g++) begin : g_e
    gpao_pin u_pin (
      .clk(REF_CLK), .rst_n(rst_n), .ce(CE),
      .latch(e_latch_r[g]), .dir(e_dir_r[g]), .pin_i(PORT_E_I[g]),
      .ovr(e_ovr[g]),
      .pad_o(PORT_E_O[g]), .pad_oe(PORT_E_OE[g]), .pad_pu(PORT_E_PU[g]), .level()
    );
  end

  // raw synchronised level of port e, reset pin read path kept separate
  logic [WE-1:0] es1_r, es2_r;
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      es1_r <= '0;
      es2_r <= '0;
    end else if (CE) begin
      es1_r <= PORT_E_I;
      es2_r <= es1_r;
    end
  end
  always_comb begin
    e_lvl    = es2_r;
    e_lvl[1] = es2_r[1] & ~e1_osc; // RULE2
    e_lvl[2] = es2_r[2] & ~e2_osc & ~alt_r[`GPAO_ALT_ADC_BIT]; // RULE13
  end

  assign S_AXI_AWREADY   = awr_r;
  assign S_AXI_WREADY    = wr_r;
  assign S_AXI_BVALID    = bv_r;
  assign S_AXI_BRESP     = bresp_r;
  assign S_AXI_ARREADY   = arr_r;
  assign S_AXI_RVALID    = rv_r;
  assign S_AXI_RDATA     = rd_r;
  assign S_AXI_RRESP     = rresp_r;
  assign RESET_PIN_LEVEL = rl_r; // RULE6

  sequence s_wr_e0;
    do_wr && awa_r == `GPAO_OFS_E_DIR && ws_r[0] && wd_r[0];
  endsequence
  chk_e0_reads_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE7
    rst_pin_mode |-> (rd_word(`GPAO_OFS_E_DIR) & 32'h1) == 32'h0)
    else $error("reset pin direction bit not zero");
  chk_e_upper_zero: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE11
    (rd_word(`GPAO_OFS_E_OUT) & ~32'h7) == 32'h0)
    else $error("port e upper bits not zero");
  chk_cmp_b_drive: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE4
    CE && alt_r[`GPAO_ALT_TMR_BIT] && !e1_osc ##1 CE |-> PORT_E_O[1] == $past(TIMER0_CMP_B_WAVE))
    else $error("compare b waveform not on pin");
  chk_osc_in_quiet: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE2
    CE && e1_osc ##1 CE |-> !PORT_E_OE[1])
    else $error("oscillator input pin driven");
  chk_osc_out_quiet: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE1
    CE && e2_osc ##1 CE |-> !PORT_E_OE[2])
    else $error("oscillator output pin driven");
  chk_rst_pin_quiet: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE6
    CE && rst_pin_mode ##1 CE |-> !PORT_E_OE[0])
    else $error("reset pin driven");
  chk_gpio_e0_dir: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE5
    ((CE && e0_gpio) and s_wr_e0) ##1 CE ##1 CE && e0_gpio |-> PORT_E_OE[0])
    else $error("port e bit 0 not driven as gpio");
  chk_b_dir_write: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE9
    CE && do_wr && ws_r[0] && awa_r == `GPAO_OFS_B_DIR |=> dir_r[W-1:0] == $past(wd_r[W-1:0]))
    else $error("port b direction write lost");
  chk_b_latch_write: assert property (@(posedge REF_CLK) disable iff (!rst_n) // RULE8
    CE && do_wr && ws_r[0] && awa_r == `GPAO_OFS_B_OUT |=> latch_r[W-1:0] == $past(wd_r[W-1:0]))
    else $error("port b latch write lost");
endmodule : gpao_top

// [tb/gpao_board_model.sv]
// board circuitry on the port pins: resolves each pad from device and board drivers
`timescale 1ns/1ps
module gpao_board_model #(
  parameter int N = 24
) (
  input  wire logic         clk,
  input  wire logic [N-1:0] pad_o,
  input  wire logic [N-1:0] pad_oe,
  input  wire logic [N-1:0] pad_pu,
  input  wire logic [N-1:0] drv_en,
  input  wire logic [N-1:0] drv_val,
  output logic      [N-1:0] pad_i
);
  logic tgl_r = 1'b0;
  always_ff @(posedge clk) tgl_r <= ~tgl_r;
  // a floating pad without pull-up wanders, so nothing may rely on it
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pad_i[i] = pad_oe[i] ? pad_o[i] : drv_en[i] ? drv_val[i] : pad_pu[i] ? 1'b1 : tgl_r;
    end
  end
endmodule : gpao_board_model

// [tb/tb.sv]
// register and pin tests of the gpio port block
`timescale 1ns/1ps
`include "gpao_params.svh"
`define CHK(g, e, m) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("[FAIL] %0t %s", $time, m); \
    end \
  end
module tb;
  logic        ref_clk, arst_n = 1'b0, ce = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rst_lvl;
  logic [1:0]  bresp, rresp;
  logic        xtal = 1'b0, extclk = 1'b0, fuse = 1'b1, wave = 1'b0;
  logic [23:0] pin_i, pin_o, pin_oe, pin_pu, drv_val = 24'hc3c3c3;
  logic [2:0]  e_i, e_o, e_oe, e_pu, e_val = 3'h5;
  int          errors = 0, samples_checked = 0;
  gpao_top u_gpao_top (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PU(pin_pu),
    .PORT_E_I(e_i), .PORT_E_O(e_o), .PORT_E_OE(e_oe), .PORT_E_PU(e_pu),
    .OSC_XTAL_MODE(xtal), .OSC_EXT_CLK_MODE(extclk), .RESET_PIN_DISABLE_FUSE(fuse),
    .TIMER0_CMP_B_WAVE(wave), .RESET_PIN_LEVEL(rst_lvl)
  );
  gpao_board_model #(.N(24)) u_board_bcd (
    .clk(ref_clk), .pad_o(pin_o), .pad_oe(pin_oe), .pad_pu(pin_pu),
    .drv_en(24'hffffff), .drv_val(drv_val), .pad_i(pin_i)
  );
  gpao_board_model #(.N(3)) u_board_e (
    .clk(ref_clk), .pad_o(e_o), .pad_oe(e_oe), .pad_pu(e_pu),
    .drv_en(3'h7), .drv_val(e_val), .pad_i(e_i)
  );
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    int   n;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b0;
    w = 1'b0;
    n = 0;
    while (!(aw && w) && n < 64) begin
      @(posedge ref_clk);
      n++;
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge ref_clk);
      n++;
    end while (bvalid !== 1'b1 && n < 128);
    bready <= 1'b0;
    `CHK(n < 128, 1'b1, "write not answered")
    `CHK(bresp, er, "write response")
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (arready !== 1'b1 && n < 64);
    arvalid <= 1'b0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rvalid !== 1'b1 && n < 128);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    `CHK(n < 128, 1'b1, "read not answered")
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e, "read data")
    `CHK(r, `GPAO_RESP_OKAY, "read response")
  endtask : rchk
  task settle;
    repeat (5) @(posedge ref_clk);
  endtask : settle
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim;
  end
  initial begin
    logic [7:0]  base;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    for (int p = 0; p < 3; p++) begin
      base = 8'(12 * p);
      rchk(base + `GPAO_OFS_B_OUT, 32'h0);
      rchk(base + `GPAO_OFS_B_DIR, 32'h0);
      wr(base + `GPAO_OFS_B_OUT, 32'hffffff5a, `GPAO_RESP_OKAY);
      wr(base + `GPAO_OFS_B_DIR, 32'h0000000f, `GPAO_RESP_OKAY);
      rchk(base + `GPAO_OFS_B_OUT, 32'h5a);
      rchk(base + `GPAO_OFS_B_DIR, 32'h0f);
      settle;
      `CHK(pin_o[8*p +: 8] & 8'h0f, 8'h0a, "pin drive")
      `CHK(pin_oe[8*p +: 8], 8'h0f, "pin enable")
      `CHK(pin_pu[8*p +: 8], 8'h50, "pin pull-up")
      rchk(base + `GPAO_OFS_B_PIN, 32'hca);
    end
    $display("test bcd registers done");
    rchk(`GPAO_OFS_E_OUT, 32'h0);
    rchk(`GPAO_OFS_E_DIR, 32'h0);
    wr(`GPAO_OFS_E_OUT, 32'hff, `GPAO_RESP_OKAY);
    wr(`GPAO_OFS_E_DIR, 32'hff, `GPAO_RESP_OKAY);
    rchk(`GPAO_OFS_E_OUT, 32'h07);
    rchk(`GPAO_OFS_E_DIR, 32'h07);
    settle;
    `CHK(e_oe, 3'h7, "port e enable")
    `CHK(e_o, 3'h7, "port e drive")
    `CHK(rst_lvl, 1'b1, "reset level with fuse")
    rchk(`GPAO_OFS_E_PIN, 32'h07);
    $display("test port e registers done");
    wr(`GPAO_OFS_E_DIR, 32'h02, `GPAO_RESP_OKAY);
    wr(`GPAO_OFS_E_OUT, 32'h00, `GPAO_RESP_OKAY);
    wave <= 1'b1;
    wr(`GPAO_OFS_ALT, 32'h1, `GPAO_RESP_OKAY);
    settle;
    `CHK(e_o[1], 1'b1, "compare high")
    ce <= 1'b0;
    wave <= 1'b0;
    settle;
    `CHK(e_o[1], 1'b1, "held while disabled")
    ce <= 1'b1;
    settle;
    `CHK(e_o[1], 1'b0, "compare low")
    wave <= 1'b1;
    wr(`GPAO_OFS_ALT, 32'h0, `GPAO_RESP_OKAY);
    settle;
    `CHK(e_o[1], 1'b0, "latch without override")
    $display("test compare output done");
    wr(`GPAO_OFS_E_DIR, 32'h00, `GPAO_RESP_OKAY);
    wr(`GPAO_OFS_E_OUT, 32'h07, `GPAO_RESP_OKAY);
    settle;
    `CHK(e_pu, 3'h7, "port e pull-up")
    rchk(`GPAO_OFS_E_PIN, 32'h05);
    wr(`GPAO_OFS_ALT, 32'h2, `GPAO_RESP_OKAY);
    settle;
    rchk(`GPAO_OFS_E_PIN, 32'h01);
    wr(`GPAO_OFS_ALT, 32'h0, `GPAO_RESP_OKAY);
    $display("test analog disable done");
    wr(`GPAO_OFS_E_DIR, 32'h07, `GPAO_RESP_OKAY);
    wr(`GPAO_OFS_E_OUT, 32'h07, `GPAO_RESP_OKAY);
    xtal <= 1'b1;
    settle;
    `CHK(e_oe, 3'h1, "crystal pins released")
    rchk(`GPAO_OFS_E_PIN, 32'h01);
    xtal <= 1'b0;
    extclk <= 1'b1;
    settle;
    `CHK(e_oe, 3'h5, "clock input released")
    extclk <= 1'b0;
    $display("test oscillator pins done");
    fuse <= 1'b0;
    e_val <= 3'h0;
    settle;
    rchk(`GPAO_OFS_E_OUT, 32'h06);
    rchk(`GPAO_OFS_E_DIR, 32'h06);
    rchk(`GPAO_OFS_E_PIN, 32'h06);
    `CHK(e_oe[0], 1'b0, "reset pin not driven")
    `CHK(rst_lvl, 1'b0, "reset level low")
    e_val <= 3'h1;
    settle;
    `CHK(rst_lvl, 1'b1, "reset level high")
    fuse <= 1'b1;
    e_val <= 3'h0;
    settle;
    `CHK(rst_lvl, 1'b1, "reset level ignored")
    `CHK(e_oe[0], 1'b1, "bit0 driven again")
    rchk(`GPAO_OFS_E_OUT, 32'h07);
    $display("test reset pin done");
    wr(`GPAO_OFS_B_PIN, 32'hff, `GPAO_RESP_OKAY);
    rchk(`GPAO_OFS_B_PIN, 32'hca);
    wr(8'h3c, 32'h1, `GPAO_RESP_SLVERR);
    rd(8'h34, d, r);
    `CHK(r, `GPAO_RESP_SLVERR, "unmapped read")
    $display("test bus errors done");
    end_sim;
  end
endmodule : tb
